// *** hdl/line_fifo.sv ***
`timescale 1ns/1ps
// small synchronous fifo with registered read data
module line_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
)
(
	input  wire logic   clock,
	input  wire logic   arst_n,
	line_fifo_if.fifo   port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];   // storage
	logic [AW-1:0]    wptr_r;          // write pointer
	logic [AW-1:0]    rptr_r;          // read pointer
	logic [AW:0]      count_r;         // words held
	logic             out_valid_r;     // output holds a word
	logic [WIDTH-1:0] out_data_r;      // registered read data
	wire              wr_en;           // accepted write
	wire              pop;             // memory word moves to output
	wire              mem_has;         // memory not empty

	assign port.in_ready  = (count_r != (AW+1)'(DEPTH));
	assign wr_en          = port.in_valid && port.in_ready;
	assign mem_has        = (count_r != '0);
	assign pop            = mem_has && (!out_valid_r || port.out_ready);
	assign port.out_valid = out_valid_r;
	assign port.out_data  = out_data_r;

	// storage write
	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem_r[wptr_r] <= port.in_data;
	end

	// pointers, count and output register
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wptr_r      <= '0;
			rptr_r      <= '0;
			count_r     <= '0;
			out_valid_r <= 1'b0;
			out_data_r  <= '0;
		end
		else
		begin
			if (wr_en)
				wptr_r <= wptr_r + 1'b1;
			if (pop)
			begin
				rptr_r     <= rptr_r + 1'b1;
				out_data_r <= mem_r[rptr_r];
			end
			count_r <= count_r + (AW+1)'(wr_en) - (AW+1)'(pop);
			if (pop)
				out_valid_r <= 1'b1;
			else if (port.out_ready)
				out_valid_r <= 1'b0;
		end
	end

endmodule : line_fifo

// *** hdl/line_fifo_if.sv ***
`timescale 1ns/1ps
// carrier between the core and its receive fifo
interface line_fifo_if #(parameter int WIDTH = 2);
	logic             in_valid;  // write side valid
	logic             in_ready;  // write side ready
	logic [WIDTH-1:0] in_data;   // write data
	logic             out_valid; // read side valid
	logic             out_ready; // read side ready
	logic [WIDTH-1:0] out_data;  // read data
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport core (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : line_fifo_if

// *** hdl/line_path.sv ***
`timescale 1ns/1ps
// Overview of operation
// - remote loop sends line input to driver
// - framer still receives; formatter output dropped
// - local loop feeds transmit data to receiver
// - local loop data passes enabled jitter attenuator
// - composite clock: AMI with 8 kHz violations
// - two variants: 8 kHz, 8 kHz plus 400 Hz
// - receiver recovers subrates from violation presence
// - violations follow transmit frame sync reference
// - free running violations without reference
// - 6312 mode drives square receive clock
// - 6312 mode floats 8 kHz and 400 Hz
// - pll output gives 50 percent square wave
// - transmit clock mirrors pll, remote uses recovered
// - 6312 mode ignores serial in and sync
// - 6312 mode floats transmit line driver
// - loopback bits reset to zero
module line_path
	import line_path_pkg::*;
#(
	parameter int FIFO_DEPTH_P = FIFO_DEPTH
)
(
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       reg_write,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       hw_mode,
	input  wire logic       remote_loop_pin,
	input  wire logic [1:0] line_mode,
	input  wire logic       jitter_atten_en,
	input  wire logic       receive_line_pos,
	input  wire logic       receive_line_neg,
	input  wire logic       transmit_frame_sync_in,
	input  wire logic       receive_serial_in,
	input  wire logic       formatter_pos,
	input  wire logic       formatter_neg,
	output logic            transmit_line_pos,
	output logic            transmit_line_neg,
	output logic            transmit_line_oe,
	output logic            framer_pos,
	output logic            framer_neg,
	output logic            framer_valid,
	output logic            receive_clock_out,
	output logic            receive_frame_sync_out,
	output logic            receive_400_out,
	output logic            receive_sub_oe,
	output logic            pll_clock_out,
	output logic            transmit_clock_out,
	output logic            serial_echo_out
);
	// pin synchronisers
	logic [7:0] sync1_r;   // first stage
	logic [7:0] sync2_r;   // second stage
	wire  [7:0] pins_raw = {receive_serial_in, remote_loop_pin, transmit_frame_sync_in,
		receive_line_neg, receive_line_pos, jitter_atten_en, hw_mode, 1'b0};
	wire        rx_pos   = sync2_r[3];
	wire        rx_neg   = sync2_r[4];
	wire        fs_in    = sync2_r[5];
	wire        rl_pin   = sync2_r[6];
	wire        ser_in   = sync2_r[7];
	wire        hw_s     = sync2_r[1];
	wire        ja_s     = sync2_r[2];

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end
		else
		begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	// loopback register
	logic [7:0] loop_ctrl_r;   // stored control bits
	wire        ctrl_hit   = reg_write && (reg_addr == LOOP_CTRL_OFFSET);
	// unused bits are kept at zero whatever is written
	wire [7:0]  ctrl_nxt   = reg_wdata & LOOP_CTRL_MASK;
	// hardware mode: remote bit from pin, every other bit zero
	wire        remote_en  = hw_s ? rl_pin : loop_ctrl_r[REMOTE_LOOP_BIT];
	wire        local_en   = hw_s ? 1'b0 : loop_ctrl_r[LOCAL_LOOP_BIT];
	wire [7:0]  ctrl_view  = hw_s ? (8'h00 | (8'(rl_pin) << REMOTE_LOOP_BIT)) : loop_ctrl_r;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			loop_ctrl_r <= LOOP_CTRL_RESET;
		else if (ctrl_hit)
			loop_ctrl_r <= ctrl_nxt;
	end

	// read data register
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_addr == LOOP_CTRL_OFFSET)
			reg_rdata <= ctrl_view;
		else
			reg_rdata <= 8'h00;
	end

	// mode decode
	line_mode_type mode;
	assign mode = line_mode_type'(line_mode);
	wire is_6312 = (mode == MODE_6312);
	wire is_cc   = (mode == MODE_CC8K) || (mode == MODE_CC400);

	// 64 kHz bit timing
	logic [15:0] tick_cnt_r;   // cycles within a half bit
	logic        half_r;       // second half of the bit
	logic [2:0]  bit_r;        // bit within 8 kHz frame
	logic [4:0]  frame_r;      // frame within 400 Hz period
	logic        last_pol_r;   // polarity of last mark
	logic        fs_d_r;       // delayed frame sync
	wire         tick_end  = (tick_cnt_r == 16'(HALF_64K_CYC - 1));
	wire         bit_end   = tick_end && half_r;
	wire         fs_rise   = fs_in && !fs_d_r;
	// frame sync realigns violation phase when present
	wire         fs_align  = fs_rise && !is_6312;
	wire         frame_end = bit_end && (bit_r == 3'(BITS_PER_8K - 1));
	// one violation dropped every twentieth frame in the 400 Hz variant
	wire         skip_bpv  = (mode == MODE_CC400) && (frame_r == 5'(FRAMES_PER_400 - 1));
	// violation on frame's first bit, free phase when no reference
	wire         bpv_bit   = (bit_r == 3'd0) && !skip_bpv;
	// AMI mark polarity: alternate, repeat on violation
	wire         mark_pol  = bpv_bit ? last_pol_r : !last_pol_r;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt_r <= 16'h0000;
			half_r     <= 1'b0;
			bit_r      <= 3'h0;
			frame_r    <= 5'h00;
			last_pol_r <= 1'b0;
			fs_d_r     <= 1'b0;
		end
		else
		begin
			fs_d_r <= fs_in;
			if (fs_align)
			begin
				tick_cnt_r <= 16'h0000;
				half_r     <= 1'b0;
				bit_r      <= 3'h0;
			end
			else
			begin
				tick_cnt_r <= tick_end ? 16'h0000 : tick_cnt_r + 16'h0001;
				if (tick_end)
					half_r <= !half_r;
				if (bit_end)
					bit_r <= bit_r + 3'h1;
			end
			if (frame_end)
				frame_r <= (frame_r == 5'(FRAMES_PER_400 - 1)) ? 5'h00 : frame_r + 5'h01;
			if (bit_end)
				last_pol_r <= mark_pol;
		end
	end

	// composite clock mark: first half of each bit
	wire cc_pos = is_cc && !half_r && mark_pol;
	wire cc_neg = is_cc && !half_r && !mark_pol;
	// formatter data replaced by line data in remote loop
	wire tx_pos_sel = remote_en ? rx_pos : (is_cc ? cc_pos : formatter_pos);
	wire tx_neg_sel = remote_en ? rx_neg : (is_cc ? cc_neg : formatter_neg);

	// transmit driver
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			transmit_line_pos <= 1'b0;
			transmit_line_neg <= 1'b0;
			transmit_line_oe  <= 1'b0;
		end
		else
		begin
			transmit_line_pos <= tx_pos_sel;
			transmit_line_neg <= tx_neg_sel;
			transmit_line_oe  <= !is_6312;
		end
	end

	// receive source: local loop uses transmitted marks
	wire lp_pos = is_cc ? cc_pos : formatter_pos;
	wire lp_neg = is_cc ? cc_neg : formatter_neg;
	wire rs_pos = local_en ? lp_pos : rx_pos;
	wire rs_neg = local_en ? lp_neg : rx_neg;

	// receive fifo models the jitter attenuator elastic store
	line_fifo_if #(.WIDTH(2)) ja_if ();
	line_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH_P)) u_ja_fifo
	(
		.clock  (clock),
		.arst_n (arst_n),
		.port   (ja_if)
	);
	// looped data also takes the attenuator path when enabled
	assign ja_if.in_valid  = ja_s;
	assign ja_if.in_data   = {rs_neg, rs_pos};
	assign ja_if.out_ready = 1'b1;
	wire [1:0] fr_data     = ja_s ? ja_if.out_data : {rs_neg, rs_pos};
	wire       fr_valid    = ja_s ? ja_if.out_valid : 1'b1;

	// framer feed, continues in remote loop
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			framer_pos   <= 1'b0;
			framer_neg   <= 1'b0;
			framer_valid <= 1'b0;
		end
		else
		begin
			framer_pos   <= fr_data[0];
			framer_neg   <= fr_data[1];
			framer_valid <= fr_valid;
		end
	end

	// receive violation detector
	logic       rx_last_pol_r;  // polarity of last received mark
	logic       rx_mark_d_r;    // previous mark level
	logic [6:0] frame_gap_r;    // set on a violation, cleared at end of bit 1
	logic       rx8k_r;         // recovered 8 kHz
	logic       rx400_r;        // recovered 400 Hz
	logic [4:0] rx_fcnt_r;      // 8 kHz frames since missing violation
	wire        rx_mark    = rs_pos || rs_neg;
	wire        mark_start = rx_mark && !rx_mark_d_r;
	wire        rx_is_bpv  = mark_start && (rs_pos == rx_last_pol_r);
	// a frame passed without violation marks the 400 Hz phase
	wire        missed_bpv = bit_end && (bit_r == 3'd1) && (frame_gap_r == 7'h00);

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_last_pol_r <= 1'b0;
			rx_mark_d_r   <= 1'b0;
			frame_gap_r   <= 7'h00;
			rx8k_r        <= 1'b0;
			rx400_r       <= 1'b0;
			rx_fcnt_r     <= 5'h00;
		end
		else
		begin
			rx_mark_d_r <= rx_mark;
			if (mark_start)
				rx_last_pol_r <= rs_pos;
			if (rx_is_bpv)
				rx8k_r <= !rx8k_r;
			if (rx_is_bpv)
				frame_gap_r <= 7'h01;
			else if (bit_end && (bit_r == 3'd1))
				frame_gap_r <= 7'h00;
			if (missed_bpv)
			begin
				rx400_r   <= !rx400_r;
				rx_fcnt_r <= 5'h00;
			end
			else if (frame_end)
				rx_fcnt_r <= rx_fcnt_r + 5'h01;
		end
	end

	// 6312 kHz square wave from the core clock
	logic [7:0] sq_cnt_r;   // half period counter
	logic       sq_r;       // square wave level
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sq_cnt_r <= 8'h00;
			sq_r     <= 1'b0;
		end
		else if (sq_cnt_r == 8'(HALF_6312_CYC - 1))
		begin
			sq_cnt_r <= 8'h00;
			sq_r     <= !sq_r;
		end
		else
			sq_cnt_r <= sq_cnt_r + 8'h01;
	end

	// recovered receive clock: 6312 input squared or 64 kHz mark edges
	wire rclk_sel = is_6312 ? rx_pos : rx_mark;

	// clock and subrate outputs
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			receive_clock_out      <= 1'b0;
			receive_frame_sync_out <= 1'b0;
			receive_400_out        <= 1'b0;
			receive_sub_oe         <= 1'b0;
			pll_clock_out          <= 1'b0;
			transmit_clock_out     <= 1'b0;
			serial_echo_out        <= 1'b0;
		end
		else
		begin
			receive_clock_out      <= rclk_sel;
			receive_frame_sync_out <= rx8k_r;
			receive_400_out        <= rx400_r;
			receive_sub_oe         <= !is_6312;
			pll_clock_out          <= is_6312 ? sq_r : !half_r;
			transmit_clock_out     <= remote_en ? rclk_sel : (is_6312 ? sq_r : !half_r);
			serial_echo_out        <= is_6312 ? 1'b0 : ser_in;
		end
	end

	// checks
	remote_route_a : assert property (@(posedge clock) disable iff (!arst_n)
		remote_en |=> (transmit_line_pos == $past(rx_pos)))
		else $error("remote loop not routing line input");
	driver_float_a : assert property (@(posedge clock) disable iff (!arst_n)
		is_6312 |=> !transmit_line_oe)
		else $error("driver enabled in 6312 mode");
	sub_float_a : assert property (@(posedge clock) disable iff (!arst_n)
		is_6312 |=> !receive_sub_oe)
		else $error("subrate outputs driven in 6312 mode");
	hw_local_a : assert property (@(posedge clock) disable iff (!arst_n)
		(hw_s && (reg_addr == LOOP_CTRL_OFFSET)) |=> ((reg_rdata & 8'hFB) == 8'h00))
		else $error("control bit other than remote read in hardware mode");
	unused_zero_a : assert property (@(posedge clock) disable iff (!arst_n)
		(loop_ctrl_r & ~LOOP_CTRL_MASK) == 8'h00)
		else $error("unused control bit set");
	echo_ignore_a : assert property (@(posedge clock) disable iff (!arst_n)
		is_6312 |=> !serial_echo_out)
		else $error("serial input not ignored");
	tclk_pll_a : assert property (@(posedge clock) disable iff (!arst_n)
		(is_6312 && !remote_en) |=> (transmit_clock_out == pll_clock_out))
		else $error("transmit clock differs from pll clock");
	sync_align_a : assert property (@(posedge clock) disable iff (!arst_n)
		fs_align |=> (bit_r == 3'd0 && tick_cnt_r == 16'h0000))
		else $error("violation phase not aligned to sync");

endmodule : line_path

// *** hdl/line_path_pkg.sv ***
package line_path_pkg;

	// loopback control register
	localparam logic [7:0] LOOP_CTRL_OFFSET   = 8'h20;
	localparam logic [7:0] LOOP_CTRL_RESET    = 8'h00;
	localparam int         REMOTE_LOOP_BIT    = 2;
	localparam int         LOCAL_LOOP_BIT     = 3;
	localparam logic [7:0] LOOP_CTRL_MASK     = 8'h0C;

	// timing at 200 MHz
	localparam int         CLOCK_KHZ          = 200000;
	localparam int         RATE_64K_KHZ       = 64;
	localparam int         BITS_PER_8K        = 8;
	localparam int         FRAMES_PER_400     = 20;
	localparam int         RATE_6312_KHZ      = 6312;
	// half period of the 64 kHz and 6312 kHz outputs, rounded down
	localparam int         HALF_64K_CYC       = CLOCK_KHZ / (2 * RATE_64K_KHZ);
	localparam int         HALF_6312_CYC      = CLOCK_KHZ / (2 * RATE_6312_KHZ);

	// line modes
	typedef enum logic [1:0]
	{
		MODE_DATA  = 2'b00,
		MODE_CC8K  = 2'b01,
		MODE_CC400 = 2'b10,
		MODE_6312  = 2'b11
	} line_mode_type;

	localparam int         FIFO_DEPTH         = 16;

endpackage : line_path_pkg

// *** verif/line_partner.sv ***
`timescale 1ns/1ps
// far end: sends a composite clock and counts the violations it receives
module line_partner
	import line_path_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        cc_en,   // composite clock on, else static levels
	input  wire logic        lvl_pos, // static receive levels
	input  wire logic        lvl_neg,
	input  wire logic        tx_pos,  // transmit marks from the device
	input  wire logic        tx_neg,
	input  wire logic        clr,     // clears the violation count
	output logic             rx_pos,
	output logic             rx_neg,
	output logic             sync_out,
	output logic      [15:0] viol_r
);
	int         cyc_r;          // cycle within a bit
	int         bit_r;          // bit within a frame
	logic       pol_r;          // polarity of the mark being sent
	logic       last_r = 1'b0;  // polarity of the last mark seen
	logic [1:0] txd_r = 2'b00;  // transmit marks one cycle ago
	wire        mark_w = cyc_r < HALF_64K_CYC;
	wire        up_w   = (tx_pos & ~txd_r[1]) | (tx_neg & ~txd_r[0]);
	// marks return to zero after half a bit
	assign rx_pos   = cc_en ? mark_w & pol_r : lvl_pos;
	assign rx_neg   = cc_en ? mark_w & ~pol_r : lvl_neg;
	// reference is high during bit 0 of each frame
	assign sync_out = cc_en & (bit_r == 0);
	// ami bits; polarity kept into bit 0 forms the violation
	always @(negedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cyc_r <= 0;
			bit_r <= 0;
			pol_r <= 1'b0;
		end
		else if (cyc_r == 2 * HALF_64K_CYC - 1)
		begin
			cyc_r <= 0;
			bit_r <= (bit_r + 1) % BITS_PER_8K;
			pol_r <= (bit_r == BITS_PER_8K - 1) ? pol_r : ~pol_r;
		end
		else
			cyc_r <= cyc_r + 1;
	end
	// a mark with the polarity of the one before is a violation
	always @(posedge clock)
	begin
		txd_r <= {tx_pos, tx_neg};
		if (clr)
			viol_r <= 16'h0000;
		else if (up_w && (tx_pos == last_r))
			viol_r <= viol_r + 16'h0001;
		if (up_w)
			last_r <= tx_pos;
	end
endmodule : line_partner

// *** verif/line_path_tb.sv ***
`timescale 1ns/1ps
// bench: register, loopbacks and clock modes of the line path
module line_path_tb
	import line_path_pkg::*;
;
	localparam int FRAME = 2 * HALF_64K_CYC * BITS_PER_8K; // cycles per frame
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic        reg_write = 1'b0;
	logic  [7:0] reg_addr = 8'h00;
	logic  [7:0] reg_wdata = 8'h00;
	logic        hw_mode = 1'b0;
	logic        remote_loop_pin = 1'b0;
	logic  [1:0] line_mode = MODE_DATA;
	logic        jitter_atten_en = 1'b0;
	logic        receive_serial_in = 1'b0;
	logic        formatter_pos = 1'b0;
	logic        formatter_neg = 1'b0;
	logic        cc_en = 1'b0;          // partner sends composite clock
	logic        lvl_pos = 1'b0;        // static receive levels
	logic        lvl_neg = 1'b0;
	logic        clr = 1'b0;            // clears measured counts
	logic        sync_d = 1'b0;         // recovered sync one cycle ago
	logic        pll_d = 1'b0;          // pll clock one cycle ago
	logic [15:0] hi_cnt = 16'h0000;     // pll high cycles so far
	logic [15:0] hi_run = 16'h0000;     // last whole high run
	logic [15:0] rx_tog = 16'h0000;     // recovered sync toggles
	logic        r4_d = 1'b0;           // recovered 400 Hz one cycle ago
	logic [15:0] r4_tog = 16'h0000;     // recovered 400 Hz toggles
	logic  [7:0] rd_v;                  // random register value
	wire  [15:0] viol;                  // violations seen by the partner
	wire   [7:0] reg_rdata;
	wire         receive_line_pos, receive_line_neg, transmit_frame_sync_in;
	wire         transmit_line_pos, transmit_line_neg, transmit_line_oe, framer_pos;
	wire         framer_neg, framer_valid, receive_clock_out, receive_frame_sync_out;
	wire         receive_400_out, receive_sub_oe, pll_clock_out, transmit_clock_out;
	wire         serial_echo_out;
	wire   [9:0] flags = {framer_valid, receive_clock_out, transmit_line_pos, transmit_line_neg,
		transmit_line_oe, framer_pos, framer_neg, receive_sub_oe, serial_echo_out,
		transmit_clock_out};
	int          bad_count = 0;
	int          n_checks = 0;
	string       nq[$];                 // pending checks: name
	int          wq[$];                 // which result
	logic [15:0] eq[$];                 // expected value
	logic [15:0] mq[$];                 // bits that count
	event        chk_ev;

	line_path #(.FIFO_DEPTH_P(FIFO_DEPTH)) line_path_i (.clock, .arst_n, .reg_write,
		.reg_addr, .reg_wdata, .reg_rdata, .hw_mode, .remote_loop_pin, .line_mode,
		.jitter_atten_en, .receive_line_pos, .receive_line_neg, .transmit_frame_sync_in,
		.receive_serial_in, .formatter_pos, .formatter_neg, .transmit_line_pos,
		.transmit_line_neg, .transmit_line_oe, .framer_pos, .framer_neg, .framer_valid,
		.receive_clock_out, .receive_frame_sync_out, .receive_400_out, .receive_sub_oe,
		.pll_clock_out, .transmit_clock_out, .serial_echo_out);
	line_partner line_partner_i (.clock, .arst_n, .cc_en, .lvl_pos, .lvl_neg,
		.tx_pos(transmit_line_pos), .tx_neg(transmit_line_neg), .clr,
		.rx_pos(receive_line_pos), .rx_neg(receive_line_neg),
		.sync_out(transmit_frame_sync_in), .viol_r(viol));

	always #2.5 clock = ~clock;

	// edge-sampled measures of recovered sync, recovered 400 Hz and pll clock
	always @(posedge clock)
	begin
		sync_d <= receive_frame_sync_out;
		pll_d  <= pll_clock_out;
		hi_cnt <= pll_clock_out ? hi_cnt + 16'h0001 : 16'h0000;
		if (pll_d && !pll_clock_out)
			hi_run <= hi_cnt;
		if (clr)
			rx_tog <= 16'h0000;
		else if (receive_frame_sync_out != sync_d)
			rx_tog <= rx_tog + 16'h0001;
		r4_d <= receive_400_out;
		if (clr)
			r4_tog <= 16'h0000;
		else if (receive_400_out != r4_d)
			r4_tog <= r4_tog + 16'h0001;
	end

	// result selected by a pending check
	function automatic logic [15:0] obs(input int w);
		case (w)
			0: obs = {8'h00, reg_rdata};
			1: obs = {6'h00, flags};
			2: obs = viol;
			3: obs = rx_tog;
			4: obs = hi_run;
			default: obs = r4_tog;
		endcase
	endfunction : obs

	task automatic compare(input string nm, input logic [15:0] e, m, g);
		n_checks++;
		if (((g ^ e) & m) !== 16'h0000)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e & m, g & m);
		end
	endtask : compare

	// watcher: drains every pending note, oldest first, whenever a result is flagged
	always
	begin
		@(chk_ev);
		while (nq.size() > 0)
			compare(nq.pop_front(), eq.pop_front(), mq.pop_front(), obs(wq.pop_front()));
	end

	task automatic expect_val(input string nm, input int w, input logic [15:0] e, m);
		nq.push_back(nm);
		wq.push_back(w);
		eq.push_back(e);
		mq.push_back(m);
		->chk_ev;
	endtask : expect_val

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [7:0] a, d);
		@(negedge clock);
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_write = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, e);
		@(negedge clock);
		reg_addr = a;
		repeat (2) @(negedge clock);
		expect_val("reg_rdata", 0, {8'h00, e}, 16'h00FF);
	endtask : rd

	// bounded wait for one flag bit
	task automatic await(input int b, input logic v);
		int n;
		for (n = 0; n < 200 && flags[b] !== v; n++)
			@(negedge clock);
		if (n == 200)
		begin
			bad_count++;
			$display("[FAIL] flag %0d expected %b seen %b", b, v, flags[b]);
			tally_and_finish();
		end
	endtask : await

	// fresh line and formatter levels, then check where each arrives
	task automatic trial(input logic rem, loc);
		logic p, n, s, rc;
		p = ~lvl_pos;
		n = ~p & 1'($urandom);
		s = 1'($urandom);
		rc = loc | p | n;
		lvl_pos = p;
		lvl_neg = n;
		formatter_pos = ~p;
		formatter_neg = p;
		receive_serial_in = s;
		repeat (3) @(negedge clock);
		await(7, rem ? p : ~p);
		await(4, loc ? ~p : p);
		expect_val("line flags", 1, {6'h00, 1'b1, rc, rem ? {p, n} : {~p, p}, 1'b1,
			loc ? {~p, p} : {p, n}, 1'b1, s, rc}, rem ? 16'h03FF : 16'h03FE);
	endtask : trial

	initial
	begin
		#490000;
		bad_count++;
		$display("[FAIL] run expected end seen timeout");
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(95));
		repeat (12) @(posedge clock);
		@(negedge clock);
		arst_n = 1'b1;
		rd(LOOP_CTRL_OFFSET, LOOP_CTRL_RESET);
		trial(1'b0, 1'b0);
		repeat (4)
		begin
			rd_v = 8'($urandom);
			wr(LOOP_CTRL_OFFSET, rd_v);
			rd(LOOP_CTRL_OFFSET, rd_v & LOOP_CTRL_MASK);
		end
		// unmapped address: write ignored, reads zero
		wr(8'h21, 8'hFF);
		rd(8'h21, 8'h00);
		rd(LOOP_CTRL_OFFSET, rd_v & LOOP_CTRL_MASK);
		wr(LOOP_CTRL_OFFSET, 8'h04);
		trial(1'b1, 1'b0);
		trial(1'b1, 1'b0);
		for (int j = 0; j < 2; j++)
		begin
			jitter_atten_en = j[0];
			wr(LOOP_CTRL_OFFSET, 8'h08);
			trial(1'b0, 1'b1);
			trial(1'b0, 1'b1);
		end
		// pin mode: remote loop follows the pin, stored local bit reads zero
		wr(LOOP_CTRL_OFFSET, 8'h08);
		hw_mode = 1'b1;
		for (int j = 1; j >= 0; j--)
		begin
			remote_loop_pin = j[0];
			repeat (4) @(negedge clock);
			rd(LOOP_CTRL_OFFSET, {5'h00, j[0], 2'b00});
			trial(j[0], 1'b0);
		end
		hw_mode = 1'b0;
		wr(LOOP_CTRL_OFFSET, 8'h00);
		line_mode = MODE_6312;
		receive_serial_in = 1'b1;
		repeat (100) @(negedge clock);
		expect_val("line flags", 1, {7'h00, lvl_pos, 8'h00}, 16'h0126);
		expect_val("pll high run", 4, 16'(HALF_6312_CYC), 16'hFFFF);
		for (int j = 0; j < 2; j++)
		begin
			line_mode = j ? MODE_CC400 : MODE_CC8K;
			cc_en = 1'b1;
			repeat (FRAME / (j + 1)) @(negedge clock);
			clr = 1'b1;
			@(negedge clock);
			clr = 1'b0;
			repeat (FRAME - 1) @(negedge clock);
			expect_val("violations", 2, 16'h0001, 16'hFFFF);
			expect_val("sync toggles", 3, 16'h0001, 16'hFFFF);
			expect_val("400 toggles", 5, 16'h0000, 16'hFFFF);
			expect_val("pll high run", 4, 16'(HALF_64K_CYC), 16'hFFFF);
		end
		// let the watcher drain the last notes before the verdict
		@(negedge clock);
		tally_and_finish();
	end
endmodule : line_path_tb
